//--- core/bsps_map.svh
// Constant map for the buck startup and protection sequencer
`ifndef BSPS_MAP_SVH
`define BSPS_MAP_SVH
// -----------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------
`define BSPS_CLK_PERIOD_NS 8
`define BSPS_CLK_KHZ       125000
`define BSPS_FSW_KHZ       600
`define BSPS_HICCUP_NS     20480000
`define BSPS_SMP_WIN_NS    30
`define BSPS_SMP_SHORT_NS  40
`define BSPS_SS_STEP_NS    1000
`define BSPS_PB_PULSES     16
`define BSPS_PB_STEPS      8
`define BSPS_ZC_CYCLES     256
// -----------------------------------------------------------------
// Soft-start ramp codes, one code is 0.4 mV
// -----------------------------------------------------------------
`define BSPS_SS_MAX        12'hea6
`define BSPS_SS_LOW        12'h177
`define BSPS_SS_HIGH       12'h753
// -----------------------------------------------------------------
// Register offsets and fields
// -----------------------------------------------------------------
`define BSPS_REG_CTRL      4'h0
`define BSPS_REG_STATUS    4'h4
`define BSPS_REG_RAMP      4'h8
`define BSPS_CTRL_RUN      0
`define BSPS_CTRL_RST      1'b1
// Strap codes
`define BSPS_STRAP_GND     2'h0
`define BSPS_STRAP_FLOAT   2'h1
`define BSPS_STRAP_VCC     2'h2
`endif

//--- core/bsps_pkg.sv
// Types for the buck startup and protection sequencer
package bsps_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SOFT,
    ST_REG,
    ST_HICCUP
  } bsps_state_t;

  typedef struct packed {
    logic [3:0]  pb_step;
    logic        pb_done;
    logic        bias_low;
    logic        oc_flag;
    logic        por;
    bsps_state_t state;
  } bsps_status_t;
endpackage : bsps_pkg

//--- core/bsps_top.sv
// Startup sequencing and protection logic of a synchronous buck
// -----------------------------------------------------------------
// Functional notes
// - Drivers off unless supply and enable good
// - Ready needs all inputs valid, starts soft-start
// - Turn on only above enable on threshold
// - Enable below off threshold forces shutdown
// - Low side off until first high pulse
// - Low side duty starts eighth, steps eighth
// - Each duty step lasts sixteen pulses
// - Ramp rises 0.4 mV per us to 1.5 V
// - Startup window fixed by ramp levels
// - Overcurrent and overvoltage active during soft-start
// - Strap picks one of three limits
// - Sample 30 ns, eighth period before valley
// - Short low side: sample 40 ns in
// - Sample above limit is overcurrent event
// - Overcurrent latches flag, grounds ramp 20.48 ms
// - Hiccup end clears flag, restarts soft-start
// - Hiccup retries without limit
// - Low bias at light load or while enable is off, else high
// - 256 zero crossings before low bias
// -----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "bsps_map.svh"

module bsps_top
  import bsps_pkg::*;
#(
  parameter int PERIOD_CYC = `BSPS_CLK_KHZ / `BSPS_FSW_KHZ,
  parameter int HICCUP_CYC = `BSPS_HICCUP_NS / `BSPS_CLK_PERIOD_NS
) (
  input  wire logic        CLK_IN,          // Oscillator clock
  input  wire logic        NRST_IN,         // Async reset, low
  input  wire logic        VCC_OK_IN,       // Gate supply above lockout
  input  wire logic        EN_ABOVE_ON_IN,  // Enable above turn-on level
  input  wire logic        EN_ABOVE_OFF_IN, // Enable above shutdown level
  input  wire logic        HS_PWM_IN,       // High side demand
  input  wire logic        LS_PWM_IN,       // Low side demand
  input  wire logic        OC_COMP_IN,      // Current above limit
  input  wire logic        OV_COMP_IN,      // Output overvoltage
  input  wire logic        ZC_IN,           // Zero crossing seen
  input  wire logic [1:0]  OC_STRAP_IN,     // Limit strap state
  input  wire logic [3:0]  ADDR_IN,         // Register address
  input  wire logic [31:0] WDATA_IN,        // Write data
  input  wire logic        WR_IN,           // Write strobe
  input  wire logic        RD_IN,           // Read strobe
  output logic [31:0]      RDATA_OUT,       // Read data
  output logic             HS_DRV_OUT,      // High side gate
  output logic             LS_DRV_OUT,      // Low side gate
  output logic [11:0]      SS_RAMP_OUT,     // Ramp code
  output logic             STARTUP_OUT,     // Output startup window
  output logic             POR_OUT,         // Power on ready
  output logic             OC_FLAG_OUT,     // Latched overcurrent
  output logic             SAMPLE_OUT,      // Current sample window
  output logic [1:0]       OC_LEVEL_OUT,    // Selected limit level
  output logic             BIAS_LOW_OUT     // Low gate-drive level
);

  // -----------------------------------------------------------------
  // Derived counts
  // -----------------------------------------------------------------
  localparam int CP = `BSPS_CLK_PERIOD_NS;
  localparam int EIGHTH_CYC = PERIOD_CYC / `BSPS_PB_STEPS;
  localparam int WIN_CYC = (`BSPS_SMP_WIN_NS + CP - 1) / CP;
  localparam int SHORT_CYC = (`BSPS_SMP_SHORT_NS + CP - 1) / CP;
  localparam int SS_CYC = `BSPS_SS_STEP_NS / CP;
  localparam logic [15:0] PER_W = 16'(PERIOD_CYC);
  localparam logic [15:0] EI_W = 16'(EIGHTH_CYC);
  localparam logic [15:0] SMP_PH = 16'(PERIOD_CYC - EIGHTH_CYC);
  localparam logic [15:0] SHORT_W = 16'(SHORT_CYC);
  localparam logic [2:0] WIN_W = 3'(WIN_CYC);
  localparam logic [7:0] SS_W = 8'(SS_CYC - 1);
  localparam logic [23:0] HIC_W = 24'(HICCUP_CYC - 1);
  localparam logic [4:0] PUL_W = 5'(`BSPS_PB_PULSES);
  localparam logic [3:0] STEP_W = 4'(`BSPS_PB_STEPS);
  localparam logic [8:0] ZC_W = 9'(`BSPS_ZC_CYCLES);

  // Parameter check
  if (PERIOD_CYC < 64 || PERIOD_CYC > 65535 || HICCUP_CYC < 2
      || HICCUP_CYC > 16777215) begin : g_chk
    $error("bsps_top: period or hiccup count out of range");
  end

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  bsps_state_t  state_r, state_nxt;
  bsps_status_t status;
  logic        en_r, run_r, strap_done_r;
  logic [1:0]  level_r;
  logic [15:0] phase_r, ls_cnt_r, hsf_ph_r;
  logic [7:0]  ss_div_r;
  logic [11:0] ramp_r;
  logic [23:0] hic_r;
  logic        oc_r, first_hs_r, pb_done_r, hs_prev_r;
  logic [4:0]  pul_r;
  logic [3:0]  step_r;
  logic [2:0]  win_r;
  logic [8:0]  zc_r;
  logic        zc_seen_r, bias_low_r;
  logic        hs_r, ls_r, smp_r, start_r, ready_r;
  logic [31:0] rdata_r;

  // -----------------------------------------------------------------
  // Decoding
  // -----------------------------------------------------------------
  // Ready needs supply, latched enable and software run
  wire por = VCC_OK_IN && en_r && run_r;
  wire active = (state_r == ST_SOFT) || (state_r == ST_REG);
  wire per_start = (phase_r == 16'h0000);
  // Overvoltage blocks the high side in soft-start and regulation
  wire hs_dem = active && HS_PWM_IN && !OV_COMP_IN;
  wire hs_rise = hs_dem && !hs_prev_r;
  wire hs_fall = !hs_dem && hs_prev_r;
  // Low side on-time limit during pre-bias stepping
  wire [15:0] ls_lim = 16'(step_r * EIGHTH_CYC);
  wire ls_ok = pb_done_r || (ls_cnt_r < ls_lim);
  // Low side stays off until the first high side pulse
  wire ls_dem = active && LS_PWM_IN && first_hs_r
                && !hs_dem && ls_ok;
  wire ls_fall = ls_r && !ls_dem;
  // Short low side on-time moves the sample point
  wire short_ls = (PER_W - hsf_ph_r) < EI_W;
  wire smp_go = ls_dem && (win_r == 3'h0) && (short_ls ?
                (ls_cnt_r == SHORT_W) : (phase_r == SMP_PH));
  wire oc_evt = active && (win_r != 3'h0) && OC_COMP_IN;
  wire ramp_tick = (ss_div_r == SS_W);
  wire hic_end = (hic_r == HIC_W);

  // Register decode
  wire wr_ctrl = WR_IN && (ADDR_IN == `BSPS_REG_CTRL);
  wire [31:0] rd_mux =
    (ADDR_IN == `BSPS_REG_CTRL)   ? {31'h0, run_r} :
    (ADDR_IN == `BSPS_REG_STATUS) ? {22'h0, status} :
    (ADDR_IN == `BSPS_REG_RAMP)   ? {20'h0, ramp_r} : 32'h0;

  // Status word
  assign status = '{pb_step: step_r, pb_done: pb_done_r,
                    bias_low: bias_low_r, oc_flag: oc_r,
                    por: por, state: state_r};

  // -----------------------------------------------------------------
  // Sequencer state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF:    if (por) state_nxt = ST_SOFT;
      ST_SOFT:   if (oc_evt) state_nxt = ST_HICCUP;
                 else if (ramp_r == `BSPS_SS_MAX) state_nxt = ST_REG;
      ST_REG:    if (oc_evt) state_nxt = ST_HICCUP;
      ST_HICCUP: if (hic_end) state_nxt = ST_SOFT;
    endcase
    if (!por) state_nxt = ST_OFF;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // Enable hysteresis between on and off thresholds
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) en_r <= 1'b0;
    else if (!EN_ABOVE_OFF_IN) en_r <= 1'b0;
    else if (EN_ABOVE_ON_IN) en_r <= 1'b1;
  end

  // Software run bit
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) run_r <= `BSPS_CTRL_RST;
    else if (wr_ctrl) run_r <= WDATA_IN[`BSPS_CTRL_RUN];
  end

  // Strap captured once after reset release
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      strap_done_r <= 1'b0;
      level_r      <= `BSPS_STRAP_FLOAT;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      level_r      <= (OC_STRAP_IN == `BSPS_STRAP_VCC) ? `BSPS_STRAP_VCC :
                      (OC_STRAP_IN == `BSPS_STRAP_GND) ? `BSPS_STRAP_GND :
                      `BSPS_STRAP_FLOAT;
    end
  end

  // -----------------------------------------------------------------
  // Switching period and soft-start ramp
  // -----------------------------------------------------------------
  // Period phase counter, held clear without ready and restarted at
  // each high side rise so the sample point tracks the valley
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) phase_r <= 16'h0000;
    else if (!por || hs_rise || phase_r == PER_W - 16'h0001) phase_r <= 16'h0000;
    else phase_r <= phase_r + 16'h0001;
  end

  // One code per microsecond while soft-starting
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ss_div_r <= 8'h00;
      ramp_r   <= 12'h000;
    end else if (state_nxt == ST_HICCUP || state_nxt == ST_OFF) begin
      // Grounded on the same edge that latches the flag
      ss_div_r <= 8'h00;
      ramp_r   <= 12'h000;
    end else if (state_r != ST_SOFT) begin
      ss_div_r <= 8'h00;
      ramp_r   <= (state_r == ST_REG) ? ramp_r : 12'h000;
    end else begin
      ss_div_r <= ramp_tick ? 8'h00 : ss_div_r + 8'h01;
      if (ramp_tick && ramp_r != `BSPS_SS_MAX)
        ramp_r <= ramp_r + 12'h001;
    end
  end

  // Hiccup timer and latched overcurrent flag
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hic_r <= 24'h000000;
      oc_r  <= 1'b0;
    end else if (!por) begin
      hic_r <= 24'h000000;
      oc_r  <= 1'b0;
    end else begin
      hic_r <= (state_r == ST_HICCUP && !hic_end) ? hic_r + 24'h000001 : 24'h000000;
      if (oc_evt) oc_r <= 1'b1;
      else if (state_r == ST_HICCUP && hic_end) oc_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Pre-bias low side stepping
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hs_prev_r  <= 1'b0;
      first_hs_r <= 1'b0;
      pb_done_r  <= 1'b0;
      pul_r      <= 5'h00;
      step_r     <= 4'h1;
      ls_cnt_r   <= 16'h0000;
      hsf_ph_r   <= 16'h0000;
    end else if (!active) begin
      hs_prev_r  <= 1'b0;
      first_hs_r <= 1'b0;
      pb_done_r  <= 1'b0;
      pul_r      <= 5'h00;
      step_r     <= 4'h1;
      ls_cnt_r   <= 16'h0000;
    end else begin
      hs_prev_r <= hs_dem;
      if (hs_rise) first_hs_r <= 1'b1;
      // Low side timer runs from high side fall
      if (hs_dem) ls_cnt_r <= 16'h0000;
      else if (ls_cnt_r != 16'hffff) ls_cnt_r <= ls_cnt_r + 16'h0001;
      if (hs_fall) hsf_ph_r <= phase_r;
      // Sixteen pulses per step, eight steps
      if (hs_rise && first_hs_r && !pb_done_r) begin
        if (pul_r == PUL_W - 5'h01) begin
          pul_r <= 5'h00;
          if (step_r == STEP_W) pb_done_r <= 1'b1;
          else step_r <= step_r + 4'h1;
        end else begin
          pul_r <= pul_r + 5'h01;
        end
      end
    end
  end

  // Sample window countdown
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) win_r <= 3'h0;
    else if (!active) win_r <= 3'h0;
    else if (smp_go) win_r <= WIN_W;
    else if (win_r != 3'h0) win_r <= win_r - 3'h1;
  end

  // -----------------------------------------------------------------
  // Gate-drive bias level selection
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      zc_r       <= 9'h000;
      zc_seen_r  <= 1'b0;
      bias_low_r <= 1'b0;
    end else if (!active) begin
      zc_r       <= 9'h000;
      zc_seen_r  <= 1'b0;
      bias_low_r <= !en_r;
    end else begin
      if (per_start) begin
        zc_seen_r <= 1'b0;
        if (!zc_seen_r) begin
          zc_r       <= 9'h000;
          bias_low_r <= 1'b0;
        end else if (zc_r != ZC_W - 9'h001) begin
          // The qualifying period after 255 counted ones is the 256th
          zc_r <= zc_r + 9'h001;
        end else begin
          bias_low_r <= 1'b1;
        end
      end else if (ls_fall && ZC_IN) begin
        zc_seen_r <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hs_r    <= 1'b0;
      ls_r    <= 1'b0;
      smp_r   <= 1'b0;
      start_r <= 1'b0;
      ready_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      hs_r    <= por && hs_dem;
      ls_r    <= por && ls_dem;
      smp_r   <= smp_go || (win_r > 3'h1);
      ready_r <= (state_nxt != ST_OFF);
      // Window closes on the edge that leaves soft-start
      start_r <= (state_r == ST_SOFT) && (state_nxt == ST_SOFT)
                 && (ramp_r >= `BSPS_SS_LOW) && (ramp_r < `BSPS_SS_HIGH);
      rdata_r <= RD_IN ? rd_mux : 32'h0;
    end
  end

  assign HS_DRV_OUT   = hs_r;
  assign LS_DRV_OUT   = ls_r;
  assign SS_RAMP_OUT  = ramp_r;
  assign STARTUP_OUT  = start_r;
  assign POR_OUT      = ready_r;
  assign OC_FLAG_OUT  = oc_r;
  assign SAMPLE_OUT   = smp_r;
  assign OC_LEVEL_OUT = level_r;
  assign BIAS_LOW_OUT = bias_low_r;
  assign RDATA_OUT    = rdata_r;

endmodule : bsps_top
`default_nettype wire

//--- tb/bsps_assertions.sv
// Port-level assertions for the startup sequencer
`timescale 1ns/1ns
`default_nettype none
module bsps_assertions #(
  parameter int PERIOD_CYC = 208,
  parameter int HICCUP_CYC = 2560000
) (
  input wire logic        CLK_IN,          // Clock
  input wire logic        NRST_IN,         // Reset, low
  input wire logic        VCC_OK_IN,       // Supply good
  input wire logic        EN_ABOVE_ON_IN,  // Enable on
  input wire logic        EN_ABOVE_OFF_IN, // Enable kept
  input wire logic        OC_COMP_IN,      // Over limit
  input wire logic        HS_DRV_OUT,      // High gate
  input wire logic        LS_DRV_OUT,      // Low gate
  input wire logic [11:0] SS_RAMP_OUT,     // Ramp
  input wire logic        STARTUP_OUT,     // Startup window
  input wire logic        POR_OUT,         // Ready
  input wire logic        OC_FLAG_OUT,     // Hiccup flag
  input wire logic [1:0]  OC_LEVEL_OUT,    // Limit code
  input wire logic        BIAS_LOW_OUT     // Low bias
);
  logic        en_r;
  logic        hs_seen_r;
  int unsigned hic_r;
  int unsigned por_r;

  // Enable latch copy, first pulse flag, run lengths
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      en_r      <= 1'h0;
      hs_seen_r <= 1'h0;
      hic_r     <= 0;
      por_r     <= 0;
    end else begin
      en_r      <= (EN_ABOVE_ON_IN | en_r) & EN_ABOVE_OFF_IN;
      hs_seen_r <= POR_OUT & !OC_FLAG_OUT & (hs_seen_r | HS_DRV_OUT);
      hic_r     <= OC_FLAG_OUT ? hic_r + 1 : 0;
      por_r     <= POR_OUT ? por_r + 1 : 0;
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  a_lockout_off: assert property (!VCC_OK_IN [*3] |-> !HS_DRV_OUT && !LS_DRV_OUT)
    else $error("gate on under lockout");
  a_ready_supply: assert property ($rose(POR_OUT) |-> $past(VCC_OK_IN))
    else $error("ready without supply");
  a_ready_enable: assert property ($rose(POR_OUT) |-> $past(en_r))
    else $error("ready without enable");
  a_shutdown_off: assert property (!EN_ABOVE_OFF_IN [*4] |-> !POR_OUT && !HS_DRV_OUT && !LS_DRV_OUT)
    else $error("active in shutdown");
  a_prebias_wait: assert property (POR_OUT && !hs_seen_r |-> !LS_DRV_OUT)
    else $error("low gate before first high pulse");
  a_ramp_slope: assert property ($changed(SS_RAMP_OUT) |-> SS_RAMP_OUT == 12'h000 ||
    (SS_RAMP_OUT == $past(SS_RAMP_OUT) + 12'h001 && SS_RAMP_OUT <= 12'hea6))
    else $error("ramp step wrong");
  a_start_window: assert property (STARTUP_OUT |-> SS_RAMP_OUT >= 12'h177 && SS_RAMP_OUT <= 12'h753)
    else $error("startup window off its levels");
  a_limit_code: assert property (OC_LEVEL_OUT != 2'h3)
    else $error("limit code out of range");
  a_oc_cause: assert property ($rose(OC_FLAG_OUT) |-> $past(OC_COMP_IN))
    else $error("flag without over limit");
  a_hiccup_entry: assert property ($rose(OC_FLAG_OUT) |-> SS_RAMP_OUT == 12'h000 ##1 !HS_DRV_OUT && !LS_DRV_OUT)
    else $error("hiccup entry wrong");
  a_hiccup_len: assert property ($fell(OC_FLAG_OUT) |-> hic_r + 1 >= HICCUP_CYC && hic_r <= HICCUP_CYC + 1)
    else $error("hiccup length wrong");
  a_bias_wait: assert property ($rose(BIAS_LOW_OUT) && POR_OUT |-> por_r >= 256 * PERIOD_CYC)
    else $error("low bias too early");
endmodule : bsps_assertions
bind bsps_top bsps_assertions #(.PERIOD_CYC(PERIOD_CYC), .HICCUP_CYC(HICCUP_CYC)) u_chk (
  .CLK_IN, .NRST_IN, .VCC_OK_IN, .EN_ABOVE_ON_IN, .EN_ABOVE_OFF_IN, .OC_COMP_IN, .HS_DRV_OUT,
  .LS_DRV_OUT, .SS_RAMP_OUT, .STARTUP_OUT, .POR_OUT, .OC_FLAG_OUT, .OC_LEVEL_OUT, .BIAS_LOW_OUT);
`default_nettype wire

//--- tb/bsps_power_model.sv
// Power stage model: PWM demand and comparators
`timescale 1ns/1ns
`default_nettype none
module bsps_power_model #(
  parameter int PERIOD_CYC = 64,
  parameter int DEAD_CYC   = 2
) (
  input  wire logic clk_in,     // Clock
  input  wire logic nrst_in,    // Reset, low
  input  wire logic hs_drv_in,  // High gate
  input  wire logic zc_req_in,  // Light load asked
  input  wire logic oc_req_in,  // Overload asked
  output logic      hs_pwm_out, // High demand
  output logic      ls_pwm_out, // Low demand
  output logic      zc_out,     // Zero crossing
  output logic      oc_out      // Over limit
);
  int unsigned phase_r;

  // Free-running switching phase
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= 0;
    end else begin
      phase_r <= (phase_r == PERIOD_CYC - 1) ? 0 : phase_r + 1;
    end
  end

  // Demand with dead time; current seen only while high side off
  assign hs_pwm_out = phase_r < PERIOD_CYC / 4;
  assign ls_pwm_out = phase_r >= PERIOD_CYC / 4 + DEAD_CYC && phase_r < PERIOD_CYC - DEAD_CYC;
  assign zc_out     = zc_req_in & !hs_pwm_out;
  assign oc_out     = oc_req_in & !hs_drv_in;
endmodule : bsps_power_model
`default_nettype wire

//--- tb/bsps_top_tb.sv
// Self-checking bench for the startup sequencer
`timescale 1ns/1ns
`default_nettype none
module bsps_top_tb;
  localparam int P = 64;
  localparam int H = 200;
  logic        clk = 1'h0, nrst = 1'h0, vcc = 1'h0, en_on = 1'h0, en_off = 1'h0;
  logic        ov = 1'h0, zc_req = 1'h0, oc_req = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [1:0]  strap = 2'h1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [11:0] ramp;
  logic [1:0]  level;
  logic        hs_pwm, ls_pwm, zc, oc, hs_drv, ls_drv, startup, por, oc_flag, sample, bias_low;
  logic        hs_q = 1'h0, smp_q = 1'h0;
  int          hs_cnt = 0, smp_cnt = 0, n_fail = 0, samples_checked = 0;

  always #4 clk = ~clk;

  bsps_top #(.PERIOD_CYC(P), .HICCUP_CYC(H)) u_dut (
    .CLK_IN(clk), .NRST_IN(nrst), .VCC_OK_IN(vcc), .EN_ABOVE_ON_IN(en_on), .EN_ABOVE_OFF_IN(en_off),
    .HS_PWM_IN(hs_pwm), .LS_PWM_IN(ls_pwm), .OC_COMP_IN(oc), .OV_COMP_IN(ov), .ZC_IN(zc),
    .OC_STRAP_IN(strap), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .HS_DRV_OUT(hs_drv), .LS_DRV_OUT(ls_drv), .SS_RAMP_OUT(ramp), .STARTUP_OUT(startup), .POR_OUT(por),
    .OC_FLAG_OUT(oc_flag), .SAMPLE_OUT(sample), .OC_LEVEL_OUT(level), .BIAS_LOW_OUT(bias_low));

  bsps_power_model #(.PERIOD_CYC(P)) u_pwr (
    .clk_in(clk), .nrst_in(nrst), .hs_drv_in(hs_drv), .zc_req_in(zc_req), .oc_req_in(oc_req),
    .hs_pwm_out(hs_pwm), .ls_pwm_out(ls_pwm), .zc_out(zc), .oc_out(oc));

  // High pulse and sample window counters
  always @(posedge clk) begin
    hs_q <= hs_drv;
    smp_q <= sample;
    hs_cnt <= !por ? 0 : hs_cnt + int'(hs_drv && !hs_q);
    smp_cnt <= smp_cnt + int'(sample && !smp_q);
  end

  // ------
  // Tasks
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'h0;
    tick(8);
    nrst <= 1'h1;
    tick(2);
  endtask : do_reset
  task automatic wait_hs(input int n);
    for (int i = 0; i < 64 * P && hs_cnt < n; i++) tick(1);
  endtask : wait_hs
  task automatic ls_width(output int w);
    w = 0;
    for (int i = 0; i < 4 * P && ls_drv; i++) tick(1);
    for (int i = 0; i < 4 * P && !ls_drv; i++) tick(1);
    for (int i = 0; i < 4 * P && ls_drv; i++) begin
      tick(1);
      w++;
    end
  endtask : ls_width
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // ------
  // Sequence
  // ------
  initial begin
    logic [31:0] d;
    int          w1, w2, w3, r0;
    tick(4);
    chk("rst_level", 32'h1, 32'(level));
    chk("rst_bias", 32'h0, 32'(bias_low));
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0];
      do_reset();
      chk("level", (s == 3) ? 32'h1 : 32'(s), 32'(level));
    end
    rd_reg(4'h0, d);
    chk("ctrl", 32'h1, d);
    rd_reg(4'hc, d);
    chk("unmapped", 32'h0, d);
    wr_reg(4'h4, 32'hff);
    rd_reg(4'h4, d);
    chk("status_ro", 32'h0, d & 32'h7);
    en_off <= 1'h1;
    en_on <= 1'h1;
    tick(8);
    chk("lockout", 32'h0, 32'({por, hs_drv}));
    en_on <= 1'h0;
    wr_reg(4'h0, 32'h0);
    vcc <= 1'h1;
    tick(8);
    chk("run_off", 32'h0, 32'(por));
    wr_reg(4'h0, 32'h1);
    tick(4);
    rd_reg(4'h4, d);
    chk("status_soft", 32'h5, d & 32'h1f);
    wait_hs(8);
    ls_width(w1);
    wait_hs(24);
    ls_width(w2);
    wait_hs(40);
    ls_width(w3);
    chk("step1", 32'h1, 32'(w1 <= P / 8));
    chk("step_inc", 32'(P / 8), 32'(w2 - w1));
    chk("step_len", 32'(P / 8), 32'(w3 - w2));
    ov <= 1'h1;
    tick(2);
    r0 = hs_cnt;
    tick(2 * P);
    chk("ov_block", 32'(r0), 32'(hs_cnt));
    ov <= 1'h0;
    zc_req <= 1'h1;
    tick(260 * P);
    chk("bias_low", 32'h1, 32'(bias_low));
    zc_req <= 1'h0;
    tick(3 * P);
    chk("bias_high", 32'h0, 32'(bias_low));
    chk("sampled", 32'h1, 32'(smp_cnt > 0));
    for (int i = 0; i < 60000 && !startup; i++) tick(1);
    chk("start_ramp", 32'h177, 32'(ramp));
    r0 = ramp;
    tick(500);
    chk("ramp_rate", 32'h4, 32'(ramp) - 32'(r0));
    oc_req <= 1'h1;
    for (int i = 0; i < 8 * P && !oc_flag; i++) tick(1);
    tick(1);
    chk("hic_ramp", 32'h0, 32'(ramp));
    rd_reg(4'h4, d);
    chk("hic_state", 32'hb, d & 32'hb);
    for (int i = 0; i < 2 * H && oc_flag; i++) tick(1);
    // Restart reruns the low side steps before a full sample window
    for (int i = 0; i < 96 * P && !oc_flag; i++) tick(1);
    chk("retry", 32'h1, 32'(oc_flag));
    oc_req <= 1'h0;
    for (int i = 0; i < 2 * H && oc_flag; i++) tick(1);
    tick(2);
    rd_reg(4'h4, d);
    chk("restart", 32'h1, d & 32'hb);
    en_off <= 1'h0;
    tick(5);
    chk("shutdown", 32'h0, 32'({por, hs_drv, ls_drv}));
    en_off <= 1'h1;
    tick(10);
    chk("need_on", 32'h0, 32'(por));
    en_on <= 1'h1;
    tick(1);
    en_on <= 1'h0;
    tick(3);
    chk("turn_on", 32'h1, 32'(por));
    chk("ramp_clear", 32'h0, 32'(ramp));
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #(8 * 70000);
    n_fail++;
    report_and_stop();
  end
endmodule : bsps_top_tb
`default_nettype wire
